// ==== pkg/recorder_pkg.sv ====
// Purpose: shared constants and types of the switch object event recorder
// Assumes: one 125 MHz clock, millisecond time base derived from it
// Notes: event codes are the indices of the event sources
package recorder_pkg;
	// time base
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned STAMP_RES_NS = 1000000;
	localparam int unsigned MS_CYCLES = STAMP_RES_NS / CLK_PERIOD_NS;

	// widths and sizes
	localparam int unsigned STAMP_W = 32;
	localparam int unsigned CNT_W = 32;
	localparam int unsigned HIST_DEPTH = 12;
	localparam int unsigned IDX_W = 4;
	localparam int unsigned EVT_N = 26;
	localparam int unsigned CODE_W = 5;
	localparam int unsigned CAUSE_W = 4;
	localparam int unsigned SRC_W = 3;
	localparam int unsigned GSTAT_W = 8;

	// reset values
	localparam logic [CNT_W-1:0] CNT_RST = 32'h0;
	localparam logic [STAMP_W-1:0] STAMP_RST = 32'h0;

	// event source indices
	localparam int unsigned EV_OBJ_BASE = 0;
	localparam int unsigned EV_CART_BASE = 4;
	localparam int unsigned EV_OPEN_REQ = 8;
	localparam int unsigned EV_OPEN_CMD = 9;
	localparam int unsigned EV_CLOSE_REQ = 10;
	localparam int unsigned EV_CLOSE_CMD = 11;
	localparam int unsigned EV_OPEN_BLK = 12;
	localparam int unsigned EV_CLOSE_BLK = 13;
	localparam int unsigned EV_READY = 14;
	localparam int unsigned EV_SYNC = 15;
	localparam int unsigned EV_OPEN_FAIL = 16;
	localparam int unsigned EV_CLOSE_FAIL = 17;
	localparam int unsigned EV_FINAL_TRIP = 18;
	localparam int unsigned EV_ABRASION = 19;
	localparam int unsigned EV_OPTIME = 20;
	localparam int unsigned EV_BRK_LOCAL = 21;
	localparam int unsigned EV_SW_LOCAL = 22;
	localparam int unsigned EV_CM_ALARM1 = 23;
	localparam int unsigned EV_CM_ALARM2 = 24;
	localparam int unsigned EV_TCS = 25;

	typedef enum logic [1:0] {
		POS_INTER = 2'h0,
		POS_OPEN = 2'h1,
		POS_CLOSED = 2'h2,
		POS_BAD = 2'h3
	} pos_t;

	typedef enum logic [1:0] {
		REC_OPEN = 2'h0,
		REC_CLOSE = 2'h1,
		REC_OPEN_FAIL = 2'h2,
		REC_CLOSE_FAIL = 2'h3
	} rec_kind_t;

	typedef enum logic [1:0] {
		OP_IDLE = 2'h0,
		OP_OPENING = 2'h1,
		OP_CLOSING = 2'h2
	} op_state_t;

	typedef struct packed {
		logic [STAMP_W-1:0] stamp;
		rec_kind_t kind;
		logic [STAMP_W-1:0] op_time;
		pos_t obj_pos;
		pos_t cart_pos;
		logic [CAUSE_W-1:0] open_cause;
		logic [CAUSE_W-1:0] close_cause;
		logic [SRC_W-1:0] open_src;
		logic [SRC_W-1:0] close_src;
		logic [GSTAT_W-1:0] gen_status;
	} history_rec_t;
endpackage

// ==== pkg/event_src_if.sv ====
// Purpose: bundle between the event edge detectors and the arbiter
// Assumes: one detector per bit, all on the same clock
// Notes: nets, since each detector drives its own bits
interface event_src_if #(parameter int unsigned N = 26);
	wire [N-1:0] level;
	wire [N-1:0] on_en;
	wire [N-1:0] off_en;
	wire [N-1:0] grant;
	wire [N-1:0] pend;
	wire [N-1:0] pol;

	modport src (input level, input on_en, input off_en, input grant,
		output pend, output pol);
	modport arb (output level, output on_en, output off_en, output grant,
		input pend, input pol);
endinterface

// ==== verilog/event_edge.sv ====
// Purpose: edge detector and pending flag for one event source
// Assumes: level comes from logic on sys_clk
// Notes: a newer edge replaces an older one still waiting
module event_edge #(
	parameter int unsigned IDX = 0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// arbiter side
	event_src_if.src ev
);
	logic level_d_ff, nxt_level_d;
	logic pend_ff, nxt_pend;
	logic pol_ff, nxt_pol;
	logic rise, fall;

	assign rise = ev.level[IDX] & ~level_d_ff;
	assign fall = ~ev.level[IDX] & level_d_ff;

	always_comb begin
		nxt_level_d = ev.level[IDX];
		nxt_pend = pend_ff & ~ev.grant[IDX];
		nxt_pol = pol_ff;
		// new edge wins over the grant of the older one
		if (rise && ev.on_en[IDX]) begin // [RULE1]
			nxt_pend = 1'b1;
			nxt_pol = 1'b1;
		end else if (fall && ev.off_en[IDX]) begin // [RULE1]
			nxt_pend = 1'b1;
			nxt_pol = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			level_d_ff <= 1'b0;
			pend_ff <= 1'b0;
			pol_ff <= 1'b0;
		end else begin
			level_d_ff <= nxt_level_d;
			pend_ff <= nxt_pend;
			pol_ff <= nxt_pol;
		end
	end

	assign ev.pend[IDX] = pend_ff;
	assign ev.pol[IDX] = pol_ff;
endmodule // event_edge

// ==== verilog/switch_object_event_recorder.sv ====
// Purpose: event, counter and history recording of one switch object
// Assumes: all status inputs come from control logic on sys_clk
// Notes: one event leaves per cycle; lowest event code goes first
//
// Functional notes
// RULE1 - Each event has its own enables for writing the on edge, the off edge or both.
// RULE2 - Every emitted event carries a time stamp counted in milliseconds.
// RULE3 - Four counters count opens, closes, failed opens and failed closes until cleared.
// RULE4 - The last twelve operations are kept as time-stamped history records.
// RULE5 - An opening record holds the time from open command to open position.
// RULE6 - A closing record holds the time from close command to closed position.
// RULE7 - Each record stores object and cart status, fail causes, sources and status.
// RULE8 - Open and close control outputs are driven and both edges of each are logged.
// RULE9 - The operating-time-exceeded condition logs on and off events.
// RULE10 - The contact abrasion alarm logs on and off events.
// RULE11 - Both condition-monitoring alarm levels log on and off events.
// RULE12 - A trip-circuit supervision fault logs events when it sets and clears.
// RULE13 - Each alarm level asserts while operations left are below its own limit.
// RULE14 - With all twelve slots full, a new record overwrites the oldest one.
// RULE15 - Each change among the four position states logs events for object and cart.
module switch_object_event_recorder #(
	parameter int unsigned MS_CYCLES = recorder_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// position indications
	input wire logic obj_open_ind,
	input wire logic obj_closed_ind,
	input wire logic cart_out_ind,
	input wire logic cart_in_ind,
	// requests, commands and states
	input wire logic open_req,
	input wire logic close_req,
	input wire logic open_cmd,
	input wire logic close_cmd,
	input wire logic open_blocked,
	input wire logic close_blocked,
	input wire logic obj_ready,
	input wire logic sync_ok,
	input wire logic open_fail,
	input wire logic close_fail,
	input wire logic final_trip,
	input wire logic abrasion_alarm,
	input wire logic optime_exceeded,
	input wire logic breaker_local,
	input wire logic switch_local,
	input wire logic tcs_fault,
	// condition monitoring
	input wire logic cm_alarm1_en,
	input wire logic cm_alarm2_en,
	input wire logic [recorder_pkg::CNT_W-1:0] ops_left,
	input wire logic [recorder_pkg::CNT_W-1:0] alarm1_limit,
	input wire logic [recorder_pkg::CNT_W-1:0] alarm2_limit,
	// record context
	input wire logic [recorder_pkg::CAUSE_W-1:0] open_fail_cause,
	input wire logic [recorder_pkg::CAUSE_W-1:0] close_fail_cause,
	input wire logic [recorder_pkg::SRC_W-1:0] open_source,
	input wire logic [recorder_pkg::SRC_W-1:0] close_source,
	input wire logic [recorder_pkg::GSTAT_W-1:0] general_status,
	// event selection
	input wire logic [recorder_pkg::EVT_N-1:0] evt_on_en,
	input wire logic [recorder_pkg::EVT_N-1:0] evt_off_en,
	// statistics
	input wire logic stats_clear,
	// control outputs and alarms
	output logic obj_open_out,
	output logic obj_close_out,
	output logic cm_alarm1,
	output logic cm_alarm2,
	// event buffer
	output logic evt_valid,
	input wire logic evt_ready,
	output logic [recorder_pkg::CODE_W-1:0] evt_code,
	output logic evt_active,
	output logic [recorder_pkg::STAMP_W-1:0] evt_stamp,
	// counters
	output logic [recorder_pkg::CNT_W-1:0] open_count,
	output logic [recorder_pkg::CNT_W-1:0] close_count,
	output logic [recorder_pkg::CNT_W-1:0] open_fail_count,
	output logic [recorder_pkg::CNT_W-1:0] close_fail_count,
	// history read
	input wire logic [recorder_pkg::IDX_W-1:0] hist_rd_idx,
	output recorder_pkg::history_rec_t hist_rd_data,
	output logic [recorder_pkg::IDX_W-1:0] hist_fill
);
	localparam int unsigned N = recorder_pkg::EVT_N;
	localparam int unsigned DEPTH = recorder_pkg::HIST_DEPTH;
	localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);
	localparam logic [recorder_pkg::IDX_W-1:0] LAST_SLOT =
		recorder_pkg::IDX_W'(DEPTH - 1);

	event_src_if #(.N(N)) ev ();

	// time base
	logic [31:0] presc_ff, nxt_presc;
	logic [recorder_pkg::STAMP_W-1:0] stamp_ff, nxt_stamp;

	always_comb begin
		nxt_presc = presc_ff + 32'h1;
		nxt_stamp = stamp_ff;
		if (presc_ff >= MS_LAST) begin
			nxt_presc = 32'h0;
			nxt_stamp = stamp_ff + 32'h1; // [RULE2]
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			presc_ff <= 32'h0;
			stamp_ff <= recorder_pkg::STAMP_RST;
		end else begin
			presc_ff <= nxt_presc;
			stamp_ff <= nxt_stamp;
		end
	end

	// positions, outputs and alarms
	recorder_pkg::pos_t obj_pos_ff, nxt_obj_pos;
	recorder_pkg::pos_t cart_pos_ff, nxt_cart_pos;
	logic open_out_ff, nxt_open_out;
	logic close_out_ff, nxt_close_out;
	logic alarm1_ff, nxt_alarm1;
	logic alarm2_ff, nxt_alarm2;
	logic open_fail_d_ff, close_fail_d_ff;

	always_comb begin
		nxt_obj_pos = recorder_pkg::pos_t'({obj_closed_ind, obj_open_ind});
		nxt_cart_pos = recorder_pkg::pos_t'({cart_in_ind, cart_out_ind});
		// a blocked direction never reaches the contact
		nxt_open_out = open_cmd & ~open_blocked; // [RULE8]
		nxt_close_out = close_cmd & ~close_blocked; // [RULE8]
		nxt_alarm1 = cm_alarm1_en & (ops_left < alarm1_limit); // [RULE13]
		nxt_alarm2 = cm_alarm2_en & (ops_left < alarm2_limit); // [RULE13]
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			obj_pos_ff <= recorder_pkg::POS_INTER;
			cart_pos_ff <= recorder_pkg::POS_INTER;
			open_out_ff <= 1'b0;
			close_out_ff <= 1'b0;
			alarm1_ff <= 1'b0;
			alarm2_ff <= 1'b0;
			open_fail_d_ff <= 1'b0;
			close_fail_d_ff <= 1'b0;
		end else begin
			obj_pos_ff <= nxt_obj_pos;
			cart_pos_ff <= nxt_cart_pos;
			open_out_ff <= nxt_open_out;
			close_out_ff <= nxt_close_out;
			alarm1_ff <= nxt_alarm1;
			alarm2_ff <= nxt_alarm2;
			open_fail_d_ff <= open_fail;
			close_fail_d_ff <= close_fail;
		end
	end

	assign obj_open_out = open_out_ff;
	assign obj_close_out = close_out_ff;
	assign cm_alarm1 = alarm1_ff;
	assign cm_alarm2 = alarm2_ff;

	// event sources
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pos
			assign ev.level[recorder_pkg::EV_OBJ_BASE + g] =
				(obj_pos_ff == recorder_pkg::pos_t'(g)); // [RULE15]
			assign ev.level[recorder_pkg::EV_CART_BASE + g] =
				(cart_pos_ff == recorder_pkg::pos_t'(g)); // [RULE15]
		end
		for (g = 0; g < N; g++) begin : g_edge
			event_edge #(.IDX(g)) u_edge (
				.sys_clk(sys_clk),
				.rst(rst),
				.ev(ev)
			);
		end
	endgenerate

	assign ev.level[recorder_pkg::EV_OPEN_REQ] = open_req;
	assign ev.level[recorder_pkg::EV_OPEN_CMD] = open_out_ff; // [RULE8]
	assign ev.level[recorder_pkg::EV_CLOSE_REQ] = close_req;
	assign ev.level[recorder_pkg::EV_CLOSE_CMD] = close_out_ff; // [RULE8]
	assign ev.level[recorder_pkg::EV_OPEN_BLK] = open_blocked;
	assign ev.level[recorder_pkg::EV_CLOSE_BLK] = close_blocked;
	assign ev.level[recorder_pkg::EV_READY] = obj_ready;
	assign ev.level[recorder_pkg::EV_SYNC] = sync_ok;
	assign ev.level[recorder_pkg::EV_OPEN_FAIL] = open_fail;
	assign ev.level[recorder_pkg::EV_CLOSE_FAIL] = close_fail;
	assign ev.level[recorder_pkg::EV_FINAL_TRIP] = final_trip;
	assign ev.level[recorder_pkg::EV_ABRASION] = abrasion_alarm; // [RULE10]
	assign ev.level[recorder_pkg::EV_OPTIME] = optime_exceeded; // [RULE9]
	assign ev.level[recorder_pkg::EV_BRK_LOCAL] = breaker_local;
	assign ev.level[recorder_pkg::EV_SW_LOCAL] = switch_local;
	assign ev.level[recorder_pkg::EV_CM_ALARM1] = alarm1_ff; // [RULE11]
	assign ev.level[recorder_pkg::EV_CM_ALARM2] = alarm2_ff; // [RULE11]
	assign ev.level[recorder_pkg::EV_TCS] = tcs_fault; // [RULE12]
	assign ev.on_en = evt_on_en;
	assign ev.off_en = evt_off_en;

	// event output stage, fixed priority by code
	logic valid_ff, nxt_valid;
	logic [recorder_pkg::CODE_W-1:0] code_ff, nxt_code;
	logic active_ff, nxt_active;
	logic [recorder_pkg::STAMP_W-1:0] ostamp_ff, nxt_ostamp;
	logic [N-1:0] grant_c;
	logic found;

	always_comb begin
		nxt_valid = valid_ff & ~evt_ready;
		nxt_code = code_ff;
		nxt_active = active_ff;
		nxt_ostamp = ostamp_ff;
		grant_c = '0;
		found = 1'b0;
		if (!valid_ff || evt_ready) begin
			for (int i = 0; i < N; i++) begin
				if (!found && ev.pend[i]) begin
					found = 1'b1;
					grant_c[i] = 1'b1;
					nxt_valid = 1'b1;
					nxt_code = recorder_pkg::CODE_W'(i);
					nxt_active = ev.pol[i];
					nxt_ostamp = stamp_ff; // [RULE2]
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			valid_ff <= 1'b0;
			code_ff <= 5'h0;
			active_ff <= 1'b0;
			ostamp_ff <= recorder_pkg::STAMP_RST;
		end else begin
			valid_ff <= nxt_valid;
			code_ff <= nxt_code;
			active_ff <= nxt_active;
			ostamp_ff <= nxt_ostamp;
		end
	end

	assign ev.grant = grant_c;
	assign evt_valid = valid_ff;
	assign evt_code = code_ff;
	assign evt_active = active_ff;
	assign evt_stamp = ostamp_ff;

	// operation tracking and counters
	recorder_pkg::op_state_t op_ff, nxt_op;
	logic [recorder_pkg::STAMP_W-1:0] start_ff, nxt_start;
	logic [recorder_pkg::CNT_W-1:0] cnt_ff [4];
	logic [recorder_pkg::CNT_W-1:0] nxt_cnt [4];
	logic open_done, close_done, open_fail_rise, close_fail_rise;
	logic wr_en;
	recorder_pkg::rec_kind_t wr_kind;

	assign open_done = (op_ff == recorder_pkg::OP_OPENING) &&
		(nxt_obj_pos == recorder_pkg::POS_OPEN);
	assign close_done = (op_ff == recorder_pkg::OP_CLOSING) &&
		(nxt_obj_pos == recorder_pkg::POS_CLOSED);
	assign open_fail_rise = open_fail & ~open_fail_d_ff;
	assign close_fail_rise = close_fail & ~close_fail_d_ff;

	always_comb begin
		nxt_op = op_ff;
		nxt_start = start_ff;
		wr_en = 1'b0;
		wr_kind = recorder_pkg::REC_OPEN;
		case (op_ff)
			recorder_pkg::OP_IDLE: begin
				if (nxt_open_out && !open_out_ff) begin // [RULE5]
					nxt_op = recorder_pkg::OP_OPENING;
					nxt_start = stamp_ff;
				end else if (nxt_close_out && !close_out_ff) begin // [RULE6]
					nxt_op = recorder_pkg::OP_CLOSING;
					nxt_start = stamp_ff;
				end
			end
			recorder_pkg::OP_OPENING: begin
				if (open_done || open_fail_rise) begin
					nxt_op = recorder_pkg::OP_IDLE;
				end
			end
			recorder_pkg::OP_CLOSING: begin
				if (close_done || close_fail_rise) begin
					nxt_op = recorder_pkg::OP_IDLE;
				end
			end
			default: begin
				nxt_op = recorder_pkg::OP_IDLE;
			end
		endcase
		// one record per cycle: completions before failures
		if (open_done) begin
			wr_en = 1'b1;
			wr_kind = recorder_pkg::REC_OPEN;
		end else if (close_done) begin
			wr_en = 1'b1;
			wr_kind = recorder_pkg::REC_CLOSE;
		end else if (open_fail_rise) begin
			wr_en = 1'b1;
			wr_kind = recorder_pkg::REC_OPEN_FAIL;
		end else if (close_fail_rise) begin
			wr_en = 1'b1;
			wr_kind = recorder_pkg::REC_CLOSE_FAIL;
		end
		// an operation in the clearing cycle still counts
		for (int k = 0; k < 4; k++) begin
			nxt_cnt[k] = stats_clear ? recorder_pkg::CNT_RST : cnt_ff[k];
		end
		if (open_done) nxt_cnt[0] = nxt_cnt[0] + 32'h1; // [RULE3]
		if (close_done) nxt_cnt[1] = nxt_cnt[1] + 32'h1; // [RULE3]
		if (open_fail_rise) nxt_cnt[2] = nxt_cnt[2] + 32'h1; // [RULE3]
		if (close_fail_rise) nxt_cnt[3] = nxt_cnt[3] + 32'h1; // [RULE3]
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			op_ff <= recorder_pkg::OP_IDLE;
			start_ff <= recorder_pkg::STAMP_RST;
			for (int k = 0; k < 4; k++) begin
				cnt_ff[k] <= recorder_pkg::CNT_RST;
			end
		end else begin
			op_ff <= nxt_op;
			start_ff <= nxt_start;
			for (int k = 0; k < 4; k++) begin
				cnt_ff[k] <= nxt_cnt[k];
			end
		end
	end

	assign open_count = cnt_ff[0];
	assign close_count = cnt_ff[1];
	assign open_fail_count = cnt_ff[2];
	assign close_fail_count = cnt_ff[3];

	// history ring
	recorder_pkg::history_rec_t hist_mem [DEPTH];
	recorder_pkg::history_rec_t wr_rec;
	recorder_pkg::history_rec_t rd_ff, nxt_rd;
	logic [recorder_pkg::IDX_W-1:0] wr_ptr_ff, nxt_wr_ptr;
	logic [recorder_pkg::IDX_W-1:0] fill_ff, nxt_fill;
	logic [recorder_pkg::IDX_W:0] rd_addr;

	always_comb begin
		wr_rec.stamp = stamp_ff;
		wr_rec.kind = wr_kind;
		wr_rec.op_time = stamp_ff - start_ff; // [RULE5] [RULE6]
		wr_rec.obj_pos = nxt_obj_pos; // [RULE7]
		wr_rec.cart_pos = nxt_cart_pos;
		wr_rec.open_cause = open_fail_cause;
		wr_rec.close_cause = close_fail_cause;
		wr_rec.open_src = open_source;
		wr_rec.close_src = close_source;
		wr_rec.gen_status = general_status;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_fill = fill_ff;
		if (wr_en) begin
			// wrap overwrites the oldest slot
			nxt_wr_ptr = (wr_ptr_ff == LAST_SLOT) ? 4'h0 :
				wr_ptr_ff + 4'h1; // [RULE14]
			if (fill_ff != recorder_pkg::IDX_W'(DEPTH)) begin // [RULE4]
				nxt_fill = fill_ff + 4'h1;
			end
		end
		// index 0 is the newest record
		rd_addr = {1'b0, wr_ptr_ff} + 5'(DEPTH) - 5'h1 - {1'b0, hist_rd_idx};
		if (rd_addr >= 5'(DEPTH)) begin
			rd_addr = rd_addr - 5'(DEPTH);
		end
		nxt_rd = '0;
		if (hist_rd_idx < fill_ff) begin
			nxt_rd = hist_mem[rd_addr[recorder_pkg::IDX_W-1:0]];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			hist_mem[wr_ptr_ff] <= wr_rec; // [RULE4]
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_ff <= 4'h0;
			fill_ff <= 4'h0;
			rd_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			fill_ff <= nxt_fill;
			rd_ff <= nxt_rd;
		end
	end

	assign hist_rd_data = rd_ff;
	assign hist_fill = fill_ff;
endmodule // switch_object_event_recorder

// ==== testbench/event_sink.sv ====
// Purpose: event buffer model that takes recorder events
// Assumes: the recorder holds an event until ready is seen high
// Notes: stall holds ready low so the hold behaviour gets exercised
module event_sink (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// recorder side
	input wire logic evt_valid,
	input wire logic [recorder_pkg::CODE_W-1:0] evt_code,
	input wire logic evt_active,
	output logic evt_ready,
	// bench side
	input wire logic stall
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] got[$];
	// nba on the edge: recorder and sink both see the old ready
	always @(posedge sys_clk) evt_ready <= !stall && !rst;
	always @(posedge sys_clk) begin
		if (!rst && evt_valid && evt_ready)
			got.push_back({evt_active, evt_code});
	end
endmodule // event_sink

// ==== testbench/recorder_properties.sv ====
// Purpose: concurrent checks on the recorder top ports
// Assumes: single clock domain, async active-high reset
// Notes: ms helper counter runs in step with the design's
module recorder_checker #(
	parameter int unsigned MS_CYCLES = 10
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// control
	input wire logic open_cmd,
	input wire logic open_blocked,
	input wire logic close_cmd,
	input wire logic close_blocked,
	input wire logic obj_open_out,
	input wire logic obj_close_out,
	// alarms
	input wire logic cm_alarm1_en,
	input wire logic cm_alarm2_en,
	input wire logic [recorder_pkg::CNT_W-1:0] ops_left,
	input wire logic [recorder_pkg::CNT_W-1:0] alarm1_limit,
	input wire logic [recorder_pkg::CNT_W-1:0] alarm2_limit,
	input wire logic cm_alarm1,
	input wire logic cm_alarm2,
	// events
	input wire logic evt_valid,
	input wire logic evt_ready,
	input wire logic [recorder_pkg::CODE_W-1:0] evt_code,
	input wire logic evt_active,
	input wire logic [recorder_pkg::STAMP_W-1:0] evt_stamp,
	// statistics
	input wire logic stats_clear,
	input wire logic [recorder_pkg::CNT_W-1:0] open_count,
	input wire logic [recorder_pkg::IDX_W-1:0] hist_fill
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [31:0] cyc_ff, nxt_cyc, ms_ff, nxt_ms;
	always_comb begin
		nxt_cyc = cyc_ff + 32'h1;
		nxt_ms = ms_ff;
		if (nxt_cyc == MS_CYCLES) begin
			nxt_cyc = 32'h0;
			nxt_ms = ms_ff + 32'h1;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cyc_ff <= 32'h0;
			ms_ff <= 32'h0;
		end else begin
			cyc_ff <= nxt_cyc;
			ms_ff <= nxt_ms;
		end
	end
	property p_open_out;
		open_cmd && !open_blocked |=> obj_open_out;
	endproperty
	a_open_out: assert property (p_open_out)
		else $error("open output missing");
	property p_close_out;
		!(close_cmd && !close_blocked) |=> !obj_close_out;
	endproperty
	a_close_out: assert property (p_close_out)
		else $error("close output without command");
	property p_alarm1;
		cm_alarm1 == $past(cm_alarm1_en && (ops_left < alarm1_limit));
	endproperty
	a_alarm1: assert property (p_alarm1)
		else $error("alarm level one wrong");
	property p_alarm2;
		cm_alarm2 == $past(cm_alarm2_en && (ops_left < alarm2_limit));
	endproperty
	a_alarm2: assert property (p_alarm2)
		else $error("alarm level two wrong");
	property p_evt_hold;
		evt_valid && !evt_ready |=> evt_valid && $stable(evt_code) &&
			$stable(evt_active) && $stable(evt_stamp);
	endproperty
	a_evt_hold: assert property (p_evt_hold)
		else $error("event changed while stalled");
	property p_evt_code;
		evt_valid |-> evt_code < 5'h1A;
	endproperty
	a_evt_code: assert property (p_evt_code)
		else $error("event code out of range");
	property p_stamp;
		evt_valid && (!$past(evt_valid) || $past(evt_ready)) |->
			evt_stamp == $past(ms_ff);
	endproperty
	a_stamp: assert property (p_stamp)
		else $error("stamp ahead of ms time");
	property p_clear;
		stats_clear |=> open_count <= 32'h1;
	endproperty
	a_clear: assert property (p_clear)
		else $error("counter not cleared");
	property p_count_step;
		$changed(open_count) |->
			open_count == $past(open_count) + 32'h1 || $past(stats_clear);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("open counter jumped");
	property p_fill;
		$changed(hist_fill) |-> hist_fill == $past(hist_fill) + 4'h1 &&
			hist_fill <= 4'hC;
	endproperty
	a_fill: assert property (p_fill)
		else $error("history fill wrong");
endmodule // recorder_checker
bind switch_object_event_recorder recorder_checker #(
	.MS_CYCLES(MS_CYCLES)) chk (.*);

// ==== testbench/switch_object_event_recorder_tb_top.sv ====
// Purpose: self-checking bench of the switch object event recorder
// Assumes: ms time base shortened to 10 clock cycles
// Notes: inputs change at the falling edge
module switch_object_event_recorder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 10;
	logic sys_clk, rst, stall, stats_clear, open_cmd, close_cmd;
	logic obj_open_ind, obj_closed_ind, cart_out_ind, cart_in_ind;
	logic cm_alarm1_en, cm_alarm2_en, cm_alarm1, cm_alarm2;
	logic obj_open_out, obj_close_out, evt_valid, evt_ready, evt_active;
	logic [25:0] src, evt_on_en, evt_off_en;
	logic [31:0] ops_left, alarm1_limit, alarm2_limit, evt_stamp;
	logic [31:0] open_count, close_count, open_fail_count, close_fail_count;
	logic [4:0] evt_code;
	logic [3:0] hist_rd_idx, hist_fill;
	recorder_pkg::history_rec_t hist_rd_data;
	int miscompares, samples_checked;
	int codes[14] = '{8, 10, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21, 22, 25};

	switch_object_event_recorder #(.MS_CYCLES(MS)) DUT (.*,
		.open_req(src[8]), .close_req(src[10]), .open_blocked(src[12]),
		.close_blocked(src[13]), .obj_ready(src[14]), .sync_ok(src[15]),
		.open_fail(src[16]), .close_fail(src[17]), .final_trip(src[18]),
		.abrasion_alarm(src[19]), .optime_exceeded(src[20]),
		.breaker_local(src[21]), .switch_local(src[22]),
		.tcs_fault(src[25]), .open_fail_cause(4'h3),
		.close_fail_cause(4'hC), .open_source(3'h5), .close_source(3'h2),
		.general_status(8'hA5));
	event_sink sink (.*);

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// searches by code, so unrelated events in between do no harm
	task automatic expect_evt(int code, logic act);
		int idx;
		idx = -1;
		for (int i = 0; i < 300 && idx < 0; i++) begin
			foreach (sink.got[k])
				if (idx < 0 && sink.got[k][4:0] == code)
					idx = k;
			if (idx < 0)
				tick(1);
		end
		check("evt_found", 32'(idx >= 0), 32'h1);
		if (idx >= 0) begin
			check("evt_active", 32'(sink.got[idx][5]), 32'(act));
			sink.got.delete(idx);
		end
	endtask

	task automatic do_op(logic opn, int d);
		time t0;
		sink.got.delete();
		t0 = $time;
		open_cmd = opn;
		close_cmd = !opn;
		tick(2);
		check("ctl_out", 32'(opn ? obj_open_out : obj_close_out), 32'h1);
		open_cmd = 0;
		close_cmd = 0;
		expect_evt(opn ? 9 : 11, 1);
		expect_evt(opn ? 9 : 11, 0);
		while ($time - t0 < d * MS * 8)
			tick(1);
		obj_open_ind = opn;
		obj_closed_ind = !opn;
		tick(3);
		hist_rd_idx = 4'h0;
		tick(2);
		check("rec_kind", 32'(hist_rd_data.kind), 32'(!opn));
		check("op_time", 32'(hist_rd_data.op_time + 1 >= d &&
			hist_rd_data.op_time <= d + 1), 32'h1);
		check("rec_pos", 32'({hist_rd_data.obj_pos, hist_rd_data.cart_pos}),
			opn ? 32'h4 : 32'h8);
		check("rec_ctx", 32'({hist_rd_data.open_cause, hist_rd_data.close_cause,
			hist_rd_data.open_src, hist_rd_data.close_src,
			hist_rd_data.gen_status}), 32'h000F2AA5);
	endtask

	task automatic t_enables;
		evt_on_en[8] = 1'b0;
		src[8] = 1'b1;
		tick(10);
		src[8] = 1'b0;
		expect_evt(8, 0);
		evt_off_en[10] = 1'b0;
		src[10] = 1'b1;
		expect_evt(10, 1);
		src[10] = 1'b0;
		tick(10);
		evt_on_en = '1;
		evt_off_en = '1;
		src[10] = 1'b1;
		expect_evt(10, 1);
		src[10] = 1'b0;
		expect_evt(10, 0);
	endtask

	task automatic t_ops;
		do_op(1, 3);
		expect_evt(0, 0);
		expect_evt(1, 1);
		check("hist_fill", 32'(hist_fill), 32'h1);
		for (int i = 1; i < 13; i++)
			do_op(i % 2 == 0, 1 + i % 3);
		check("open_count", open_count, 32'h7);
		check("close_count", close_count, 32'h6);
		check("hist_fill", 32'(hist_fill), 32'hC);
		hist_rd_idx = 4'hB;
		tick(2);
		check("oldest_kind", 32'(hist_rd_data.kind), 32'h1);
	endtask

	task automatic t_alarms;
		cm_alarm1_en = 1'b1;
		cm_alarm2_en = 1'b1;
		ops_left = 32'h64;
		tick(3);
		check("alarm1", 32'(cm_alarm1), 32'h1);
		check("alarm2", 32'(cm_alarm2), 32'h0);
		expect_evt(23, 1);
		stall = 1'b1;
		ops_left = 32'h63;
		tick(6);
		stall = 1'b0;
		check("alarm2", 32'(cm_alarm2), 32'h1);
		expect_evt(24, 1);
		ops_left = 32'h3E8;
		expect_evt(23, 0);
		expect_evt(24, 0);
		check("alarm1", 32'(cm_alarm1), 32'h0);
	endtask

	task automatic t_cart_src;
		cart_in_ind = 1'b1;
		expect_evt(4, 0);
		expect_evt(6, 1);
		cart_out_ind = 1'b1;
		expect_evt(6, 0);
		expect_evt(7, 1);
		obj_closed_ind = 1'b1;
		expect_evt(3, 1);
		foreach (codes[i]) begin
			src[codes[i]] = 1'b1;
			expect_evt(codes[i], 1);
			src[codes[i]] = 1'b0;
			expect_evt(codes[i], 0);
		end
		hist_rd_idx = 4'h0;
		tick(2);
		check("fail_kind", 32'(hist_rd_data.kind), 32'h3);
		check("open_fails", open_fail_count, 32'h1);
		check("close_fails", close_fail_count, 32'h1);
		stats_clear = 1'b1;
		tick(1);
		stats_clear = 1'b0;
		tick(2);
		check("cleared", open_count | close_count | open_fail_count |
			close_fail_count, 32'h0);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial begin
		#400000;
		miscompares++;
		finish_test();
	end

	initial begin
		{rst, evt_on_en, evt_off_en} = '1;
		{stall, stats_clear, open_cmd, close_cmd, src} = '0;
		{obj_open_ind, obj_closed_ind, cart_out_ind, cart_in_ind} = '0;
		{cm_alarm1_en, cm_alarm2_en, hist_rd_idx} = '0;
		ops_left = 32'hFFFFFFFF;
		alarm1_limit = 32'h3E8;
		alarm2_limit = 32'h64;
		miscompares = 0;
		samples_checked = 0;
		tick(16);
		rst = 1'b0;
		expect_evt(0, 1);
		expect_evt(4, 1);
		t_enables();
		t_ops();
		t_alarms();
		t_cart_src();
		finish_test();
	end
endmodule // switch_object_event_recorder_tb_top
